// [verification/cpu_core_model.sv]
// model of the core side: i/o register writes and reads
// assumes a registered read answer and a level stall input
`timescale 1ns/100ps
`default_nettype none

module cpu_core_model (
	input wire logic ref_clk,
	input wire logic cpu_halt,
	input wire logic [7:0] io_rdata,
	output logic [1:0] io_sel,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	output logic hung
);
	initial begin
		io_sel = 2'h0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
		hung = 1'b0;
	end

	// a stalled core issues nothing; bounded so a stuck stall is reported
	task automatic wait_run();
		int n;
		n = 0;
		@(posedge ref_clk);
		while (cpu_halt && n < 20) begin
			n++;
			@(posedge ref_clk);
		end
		if (cpu_halt) hung <= 1'b1;
	endtask

	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		wait_run();
		io_sel <= sel;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge ref_clk);
		io_wr <= 1'b0;
		// released data bus must not keep looking valid
		io_wdata <= ~d;
	endtask

	task automatic rd(input logic [1:0] sel, output logic [7:0] d);
		wait_run();
		io_sel <= sel;
		io_rd <= 1'b1;
		@(posedge ref_clk);
		io_rd <= 1'b0;
		@(posedge ref_clk);
		#1 d = io_rdata;
	endtask
endmodule // cpu_core_model

`default_nettype wire

// [verification/eeprom_program_read_control_test.sv]
// testbench for the nonvolatile store controller
// assumes cpu_core_model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none

module eeprom_program_read_control_test;
	localparam int AT = 8;
	localparam int ST = 3;
	localparam logic [1:0] CT = nv_ctrl_pkg::SEL_CTRL;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b1;
	logic global_irq_en = 1'b1;
	logic cal_osc = 1'b0;
	logic [1:0] io_sel;
	logic io_wr, io_rd, cpu_halt, ready_irq, hung;
	logic [7:0] io_wdata, io_rdata, d;
	int n_errors = 0;
	int n_checks = 0;
	int cyc, tk;
	logic [7:0] want;
	time t0;
	typedef struct packed {logic [1:0] m; logic [1:0] gap; logic [7:0] dat; logic [7:0] exp;} row_t;
	// write-only ands into the old byte, reserved code leaves it alone
	row_t rows [5] = '{'{2'h0, 2'h0, 8'h3C, 8'h3C}, '{2'h1, 2'h2, 8'h00, 8'hFF},
		'{2'h2, 2'h0, 8'hA5, 8'hA5}, '{2'h2, 2'h2, 8'h0F, 8'h05}, '{2'h3, 2'h0, 8'h00, 8'h05}};
	`define CHK(g, e) begin \
		n_checks++; \
		if ((g) !== (e)) begin \
			n_errors++; \
			$display("mismatch at %0t: got %h want %h", $time, g, e); \
		end \
	end

	initial forever #50 ref_clk = ~ref_clk;
	// timing oscillator, unrelated in phase to ref_clk
	always #430 cal_osc = ~cal_osc;
	always @(posedge hung) begin
		n_errors++;
		close_out();
	end

	nv_program_control #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) nv_program_control_i (.ref_clk(ref_clk),
		.rst(rst), .por(por), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .global_irq_en(global_irq_en), .cal_osc(cal_osc), .cpu_halt(cpu_halt),
		.ready_irq(ready_irq));
	cpu_core_model cpu_core_model_i (.ref_clk(ref_clk), .cpu_halt(cpu_halt), .io_rdata(io_rdata),
		.io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .hung(hung));

	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// software sequences
	// ----------------------------------------------------------------
	task automatic prog(input logic [1:0] m, input int gap, input logic [7:0] dat);
		cpu_core_model_i.wr(nv_ctrl_pkg::SEL_ADDR_LO, 8'hA5);
		cpu_core_model_i.wr(nv_ctrl_pkg::SEL_ADDR_HI, 8'h01);
		cpu_core_model_i.wr(nv_ctrl_pkg::SEL_DATA, dat);
		cpu_core_model_i.wr(CT, {2'b00, m, 4'h8});
		cpu_core_model_i.wr(CT, {2'b00, m, 4'hC});
		repeat (gap) @(posedge ref_clk);
		cpu_core_model_i.wr(CT, {2'b00, m, 4'hA});
		t0 = $time;
	endtask

	// bounded poll of the busy bit before any read
	task automatic poll();
		for (int i = 0; i < 60 && d[1] !== 1'b0; i++) cpu_core_model_i.rd(CT, d);
		if (d[1] !== 1'b0) begin
			n_errors++;
			close_out();
		end
	endtask

	task automatic read_back(input logic [7:0] e);
		cpu_core_model_i.wr(CT, 8'h01);
		cpu_core_model_i.rd(nv_ctrl_pkg::SEL_DATA, d);
		`CHK(d, e)
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		por <= 1'b0;
		cpu_core_model_i.rd(CT, d);
		`CHK(d, nv_ctrl_pkg::CTRL_RESET)
		foreach (rows[i]) begin
			prog(rows[i].m, rows[i].gap, rows[i].dat);
			cpu_core_model_i.rd(CT, d);
			want = {2'b00, rows[i].m, 2'b00, rows[i].m != nv_ctrl_pkg::MODE_RSVD, 1'b0};
			`CHK(d & 8'h32, want)
			if (d[1] === 1'b1) begin
				// mode change, read strobe and address move, all while busy
				cpu_core_model_i.wr(CT, {2'b00, ~rows[i].m, 4'hB});
				// looked at right after the refused strobe, before a wait could hide a stall
				#1 `CHK(cpu_halt, 1'b0)
				cpu_core_model_i.wr(nv_ctrl_pkg::SEL_ADDR_LO, 8'h00);
				cpu_core_model_i.rd(CT, d);
				`CHK(d & 8'h33, {2'b00, rows[i].m, 4'h2})
				poll();
				cyc = int'(($time - t0) / 100);
				tk = (rows[i].m == nv_ctrl_pkg::MODE_ATOMIC) ? AT : ST;
				`CHK(cyc > tk * 8 - 8 && cyc < tk * 9 + 9, 1'b1)
				`CHK(ready_irq, 1'b1)
			end
			read_back(rows[i].exp);
		end
		// late arming and arming in the same write both start nothing
		cpu_core_model_i.wr(CT, 8'h0C);
		cpu_core_model_i.rd(CT, d);
		`CHK(d[2], 1'b1)
		cpu_core_model_i.wr(CT, 8'h0A);
		cpu_core_model_i.rd(CT, d);
		`CHK(d & 8'h06, 8'h00)
		cpu_core_model_i.wr(CT, 8'h06);
		cpu_core_model_i.rd(CT, d);
		`CHK(d[1], 1'b0)
		// reset while idle clears the mode field
		cpu_core_model_i.wr(CT, 8'h10);
		@(posedge ref_clk) rst <= 1'b1;
		@(posedge ref_clk) rst <= 1'b0;
		cpu_core_model_i.rd(CT, d);
		`CHK(d, 8'h00)
		// reset while programming keeps mode and finishes the write
		prog(nv_ctrl_pkg::MODE_WRITE, 0, 8'h04);
		@(posedge ref_clk) rst <= 1'b1;
		@(posedge ref_clk) rst <= 1'b0;
		cpu_core_model_i.rd(CT, d);
		`CHK(d & 8'h32, 8'h22)
		poll();
		read_back(8'h04);
		// ready request follows the global flag
		cpu_core_model_i.wr(CT, 8'h08);
		@(posedge ref_clk) global_irq_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 `CHK(ready_irq, 1'b0)
		close_out();
	end
endmodule // eeprom_program_read_control_test

`default_nettype wire

// [verification/nv_ctrl_assertions.sv]
// port checker for the nonvolatile store controller
// assumes it is bound to every nv_program_control instance
`timescale 1ns/100ps
`default_nettype none

module nv_ctrl_assertions (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [1:0] io_sel,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic global_irq_en,
	input wire logic cal_osc,
	input wire logic cpu_halt,
	input wire logic ready_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst || por);

	// ----------------------------------------------------------------
	// arming window shadow
	// ----------------------------------------------------------------
	// control writes decoded once so every property agrees on them
	wire ctl_wr = io_wr && io_sel == nv_ctrl_pkg::SEL_CTRL;
	wire prog_wr = ctl_wr && io_wdata[nv_ctrl_pkg::CTRL_PROG_BIT]
		&& !io_wdata[nv_ctrl_pkg::CTRL_READ_BIT];
	wire read_wr = ctl_wr && io_wdata[nv_ctrl_pkg::CTRL_READ_BIT]
		&& !io_wdata[nv_ctrl_pkg::CTRL_PROG_BIT];
	wire arm_wr = ctl_wr && io_wdata[nv_ctrl_pkg::CTRL_MASTER_BIT];
	wire strobe_wr = ctl_wr && (io_wdata[nv_ctrl_pkg::CTRL_READ_BIT]
		|| io_wdata[nv_ctrl_pkg::CTRL_PROG_BIT]);
	wire rie_off_wr = ctl_wr && !io_wdata[nv_ctrl_pkg::CTRL_RIE_BIT];
	logic [2:0] win_r;
	logic [2:0] win_nxt;
	// generous: any write with the master bit re-opens the window
	assign win_nxt = arm_wr ? nv_ctrl_pkg::MASTER_WINDOW_CYCLES :
		(win_r != 3'h0) ? win_r - 3'h1 : 3'h0;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) win_r <= 3'h0;
		else win_r <= win_nxt;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence halt_rise_s;
		$rose(cpu_halt);
	endsequence
	a_read_halt_four: assert property (halt_rise_s and $past(read_wr)
		|-> cpu_halt [*4] ##1 !cpu_halt)
		else $error("read stall not four cycles");
	a_prog_halt_two: assert property (halt_rise_s and $past(prog_wr)
		|-> cpu_halt [*2] ##1 !cpu_halt)
		else $error("program stall not two cycles");
	a_halt_has_cause: assert property (halt_rise_s |-> $past(strobe_wr))
		else $error("stall without a strobe");
	a_arm_window: assert property (halt_rise_s and $past(prog_wr)
		|-> $past(win_r != 3'h0))
		else $error("program started outside window");
	a_busy_not_ready: assert property (halt_rise_s and $past(prog_wr)
		|=> !ready_irq [*8])
		else $error("ready while programming");
	a_irq_needs_gie: assert property (ready_irq |-> $past(global_irq_en))
		else $error("ready request without global flag");
	a_irq_level_holds: assert property (ready_irq && global_irq_en
		&& !ctl_wr && !$past(ctl_wr) |=> ready_irq)
		else $error("ready request dropped");
	a_irq_off_clear: assert property (rie_off_wr |=> ##1 !ready_irq)
		else $error("ready request after enable cleared");
endmodule // nv_ctrl_assertions

bind nv_program_control nv_ctrl_assertions nv_ctrl_assertions_i (.ref_clk(ref_clk), .rst(rst),
	.por(por), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .global_irq_en(global_irq_en), .cal_osc(cal_osc),
	.cpu_halt(cpu_halt), .ready_irq(ready_irq));

`default_nettype wire

// [verilog/nv_byte_array.sv]
// byte array standing in for the nonvolatile cells
// assumes one read and one write port on the same clock, read data registered
`timescale 1ns/100ps
`default_nettype none

module nv_byte_array #(
	parameter int ADDR_W = 9,
	parameter int DATA_W = 8
) (
	input wire logic clk,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data
);

	logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

	// ----------------------------------------------------------------
	// access
	// ----------------------------------------------------------------
	// no reset: cell contents survive resets like real storage
	always_ff @(posedge clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end

endmodule // nv_byte_array

`default_nettype wire

// [verilog/nv_ctrl_pkg.sv]
// constants shared by the nonvolatile byte store controller
// assumes a byte-wide cpu i/o register port and a slow calibrated timing oscillator
package nv_ctrl_pkg;

	// ----------------------------------------------------------------
	// register selects on the cpu i/o port
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_DATA = 2'h1;
	localparam logic [1:0] SEL_ADDR_LO = 2'h2;
	localparam logic [1:0] SEL_ADDR_HI = 2'h3;

	// ----------------------------------------------------------------
	// nv_control field positions
	// ----------------------------------------------------------------
	localparam int CTRL_READ_BIT = 0;
	localparam int CTRL_PROG_BIT = 1;
	localparam int CTRL_MASTER_BIT = 2;
	localparam int CTRL_RIE_BIT = 3;
	localparam int CTRL_MODE_LO_BIT = 4;
	localparam int CTRL_MODE_HI_BIT = 5;

	// ----------------------------------------------------------------
	// programming modes and values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_ATOMIC = 2'h0;
	localparam logic [1:0] MODE_ERASE = 2'h1;
	localparam logic [1:0] MODE_WRITE = 2'h2;
	localparam logic [1:0] MODE_RSVD = 2'h3;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam logic [2:0] MASTER_WINDOW_CYCLES = 3'h4;
	localparam logic [2:0] PROG_HALT_CYCLES = 3'h2;
	localparam logic [2:0] READ_HALT_CYCLES = 3'h4;
	localparam longint ATOMIC_TIME_NS = 3400000;
	localparam longint SPLIT_TIME_NS = 1800000;
	localparam longint NS_PER_S = 1000000000;

	// programming engine states
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_BUSY = 2'b01,
		ENG_FETCH = 2'b10,
		ENG_COMMIT = 2'b11
	} eng_state_t;

endpackage

// [verilog/nv_program_control.sv]
// nonvolatile byte store controller: cpu i/o registers, read path, timed programming
// assumes the core writes registers on io_wr, reads them registered one cycle after io_rd,
// and that cal_osc is a free-running level from the calibrated oscillator below ref_clk/2
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1: program enable runs atomic 3.4 ms, erase 1.8 ms or write 1.8 ms by mode.
// R2: mode field writes are ignored while program enable is set.
// R3: reset clears mode to 00 unless programming is in progress.
// R4: ready interrupt needs enable bit and core global interrupt flag.
// R5: ready interrupt is a level held while the store is ready.
// R6: master program enable clears itself four cycles after being written.
// R7: program enable starts only while master program enable is still set.
// R8: program enable with master enable clear does nothing.
// R9: program enable reads one for the whole operation, then clears.
// R10: starting programming halts the cpu for two cycles.
// R11: read strobe loads the addressed byte into the data register.
// R12: a read halts the cpu for four cycles.
// R13: during programming, reads and address changes are refused.
// R14: during programming every other store operation is refused.
// R15: software polls program enable low before reading.
// R16: software loads address, data, mode, master enable, then program enable.
// R17: software erases before write-only, else the byte is lost.
// R18: programming time is counted on the calibrated oscillator.
// R19: a reset during programming lets the operation complete.
// R20: bytes are addressed linearly; address is undefined after reset.
// R21: reserved mode 11 starts nothing and leaves the array alone.
// R22: programming tick counts are parameters derived from oscillator frequency.
module nv_program_control #(
	parameter int ADDR_W = 9,
	parameter longint OSC_HZ = 1000000,
	parameter int CNT_W = 16,
	parameter int ATOMIC_TICKS = int'((nv_ctrl_pkg::ATOMIC_TIME_NS * OSC_HZ
		+ nv_ctrl_pkg::NS_PER_S - 1) / nv_ctrl_pkg::NS_PER_S),
	parameter int SPLIT_TICKS = int'((nv_ctrl_pkg::SPLIT_TIME_NS * OSC_HZ
		+ nv_ctrl_pkg::NS_PER_S - 1) / nv_ctrl_pkg::NS_PER_S)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [1:0] io_sel,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic global_irq_en,
	input wire logic cal_osc,
	output logic cpu_halt,
	output logic ready_irq
);

	localparam int HI_W = ADDR_W - 8;
	// tick loads sized to the counter; [R22]
	localparam logic [CNT_W-1:0] ATOMIC_LOAD = CNT_W'(ATOMIC_TICKS);
	localparam logic [CNT_W-1:0] SPLIT_LOAD = CNT_W'(SPLIT_TICKS);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	nv_ctrl_pkg::eng_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [ADDR_W-1:0] eng_addr_r;
	logic [7:0] eng_data_r;
	logic osc_s1_r, osc_s2_r, osc_s3_r, osc_lvl_r;
	logic rie_r;
	logic mpe_r;
	logic [2:0] mpe_cnt_r, mpe_cnt_nxt;
	logic [2:0] halt_cnt_r, halt_cnt_nxt;
	logic cpu_halt_r;
	logic irq_r;
	logic [7:0] io_rdata_r, rdata_nxt;
	logic rd_pending_r;
	logic [ADDR_W-1:0] addr_r;
	logic [7:0] data_r;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// write strobes and request qualification
	wire idle = (state_r == nv_ctrl_pkg::ENG_IDLE);
	wire busy = !idle;
	wire ctrl_wr = io_wr && (io_sel == nv_ctrl_pkg::SEL_CTRL);
	wire data_wr = io_wr && (io_sel == nv_ctrl_pkg::SEL_DATA);
	wire addr_lo_wr = io_wr && (io_sel == nv_ctrl_pkg::SEL_ADDR_LO) && idle; // [R13]
	wire addr_hi_wr = io_wr && (io_sel == nv_ctrl_pkg::SEL_ADDR_HI) && idle; // [R13]
	wire prog_wr = ctrl_wr && io_wdata[nv_ctrl_pkg::CTRL_PROG_BIT];
	wire mode_ok = (mode_r != nv_ctrl_pkg::MODE_RSVD); // [R21]
	// master window gates the start; a busy engine refuses it
	wire start_req = prog_wr && mpe_r && idle && mode_ok && !rst; // [R7] [R8] [R14]
	wire rd_req = ctrl_wr && io_wdata[nv_ctrl_pkg::CTRL_READ_BIT] && idle
		&& !start_req; // [R11] [R13] [R14]
	wire master_wr = ctrl_wr && io_wdata[nv_ctrl_pkg::CTRL_MASTER_BIT];
	wire mode_wr = ctrl_wr && idle && !start_req; // [R2]

	// oscillator edge, taken once the second and third stages agree
	wire osc_tick = osc_s2_r && osc_s3_r && !osc_lvl_r; // [R18]
	wire last_tick = osc_tick && (cnt_r == CNT_ONE);

	// ----------------------------------------------------------------
	// array access
	// ----------------------------------------------------------------
	wire fetch = (state_r == nv_ctrl_pkg::ENG_FETCH);
	wire commit = (state_r == nv_ctrl_pkg::ENG_COMMIT);
	wire arr_rd_en = rd_req || fetch;
	wire [ADDR_W-1:0] arr_rd_addr = fetch ? eng_addr_r : addr_r; // [R20]
	wire [7:0] arr_rd_data;
	// write-only can only clear bits, so unerased cells end up mixed
	wire [7:0] merged = arr_rd_data & eng_data_r; // [R17]
	wire [7:0] erased = nv_ctrl_pkg::ERASED_BYTE;
	wire [7:0] commit_data = (mode_r == nv_ctrl_pkg::MODE_ERASE) ? erased :
		(mode_r == nv_ctrl_pkg::MODE_WRITE) ? merged : eng_data_r; // [R1]

	nv_byte_array #(
		.ADDR_W(ADDR_W),
		.DATA_W(8)
	) u_array (
		.clk(ref_clk),
		.rd_en(arr_rd_en),
		.rd_addr(arr_rd_addr),
		.rd_data(arr_rd_data),
		.wr_en(commit),
		.wr_addr(eng_addr_r),
		.wr_data(commit_data)
	);

	// ----------------------------------------------------------------
	// programming engine
	// ----------------------------------------------------------------
	// counts oscillator ticks, then reads back the cell and commits it
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			nv_ctrl_pkg::ENG_IDLE: begin
				if (start_req) begin
					state_nxt = nv_ctrl_pkg::ENG_BUSY;
					cnt_nxt = (mode_r == nv_ctrl_pkg::MODE_ATOMIC) ?
						ATOMIC_LOAD : SPLIT_LOAD; // [R1] [R22]
				end
			end
			nv_ctrl_pkg::ENG_BUSY: begin
				if (last_tick) begin
					state_nxt = nv_ctrl_pkg::ENG_FETCH; // [R18]
				end else if (osc_tick) begin
					cnt_nxt = cnt_r - CNT_ONE;
				end
			end
			nv_ctrl_pkg::ENG_FETCH: begin
				state_nxt = nv_ctrl_pkg::ENG_COMMIT;
			end
			nv_ctrl_pkg::ENG_COMMIT: begin
				state_nxt = nv_ctrl_pkg::ENG_IDLE; // [R9]
			end
		endcase
	end

	// mode field: frozen while busy, cleared by system reset only when idle
	always_comb begin
		mode_nxt = mode_r;
		if (rst && idle) begin
			mode_nxt = nv_ctrl_pkg::MODE_RESET; // [R3]
		end else if (mode_wr) begin
			mode_nxt = io_wdata[nv_ctrl_pkg::CTRL_MODE_HI_BIT:nv_ctrl_pkg::CTRL_MODE_LO_BIT];
		end
	end

	// engine sits on power-on reset only, so a system reset cannot abort it
	always_ff @(posedge ref_clk or posedge por) begin
		if (por) begin
			state_r <= nv_ctrl_pkg::ENG_IDLE;
			cnt_r <= '0;
			mode_r <= nv_ctrl_pkg::MODE_RESET;
		end else begin
			state_r <= state_nxt; // [R19]
			cnt_r <= cnt_nxt;
			mode_r <= mode_nxt; // [R3]
		end
	end

	// target byte latched at start so later register writes cannot disturb it
	always_ff @(posedge ref_clk) begin
		if (start_req) begin
			eng_addr_r <= addr_r;
			eng_data_r <= data_r;
		end
	end

	// oscillator synchroniser, three stages
	always_ff @(posedge ref_clk or posedge por) begin
		if (por) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
			osc_lvl_r <= 1'b0;
		end else begin
			osc_s1_r <= cal_osc;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
			// level follows only agreeing stages, so one slow edge counts once
			if (osc_s2_r == osc_s3_r) begin
				osc_lvl_r <= osc_s3_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// master window and cpu halt
	// ----------------------------------------------------------------
	// window reloads on each arming write and runs out after four cycles
	always_comb begin
		mpe_cnt_nxt = mpe_cnt_r;
		if (master_wr) begin
			mpe_cnt_nxt = nv_ctrl_pkg::MASTER_WINDOW_CYCLES; // [R6]
		end else if (mpe_cnt_r != 3'h0) begin
			mpe_cnt_nxt = mpe_cnt_r - 3'h1;
		end
	end

	// halt length depends on which operation was accepted
	always_comb begin
		halt_cnt_nxt = halt_cnt_r;
		if (start_req) begin
			halt_cnt_nxt = nv_ctrl_pkg::PROG_HALT_CYCLES; // [R10]
		end else if (rd_req) begin
			halt_cnt_nxt = nv_ctrl_pkg::READ_HALT_CYCLES; // [R12]
		end else if (halt_cnt_r != 3'h0) begin
			halt_cnt_nxt = halt_cnt_r - 3'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mpe_cnt_r <= 3'h0;
			mpe_r <= 1'b0;
			halt_cnt_r <= 3'h0;
			cpu_halt_r <= 1'b0;
		end else begin
			mpe_cnt_r <= mpe_cnt_nxt;
			mpe_r <= (mpe_cnt_nxt != 3'h0); // [R6]
			halt_cnt_r <= halt_cnt_nxt;
			cpu_halt_r <= (halt_cnt_nxt != 3'h0); // [R10] [R12]
		end
	end

	// ----------------------------------------------------------------
	// interrupt enable and ready level
	// ----------------------------------------------------------------
	// a level, not a pulse: it stays up while the engine idles with enable bit and global flag set
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rie_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				rie_r <= io_wdata[nv_ctrl_pkg::CTRL_RIE_BIT]; // [R4]
			end
			irq_r <= rie_r && global_irq_en && idle; // [R4] [R5]
		end
	end

	// ----------------------------------------------------------------
	// address and data registers
	// ----------------------------------------------------------------
	// address left unreset; software must load it before any access
	always_ff @(posedge ref_clk) begin
		if (addr_lo_wr) begin
			addr_r[7:0] <= io_wdata; // [R13] [R20]
		end
		if (addr_hi_wr) begin
			addr_r[ADDR_W-1:8] <= io_wdata[HI_W-1:0]; // [R13] [R20]
		end
		// read result wins over a cpu write in the same cycle
		if (rd_pending_r) begin
			data_r <= arr_rd_data; // [R11]
		end else if (data_wr) begin
			data_r <= io_wdata;
		end
	end

	// ----------------------------------------------------------------
	// read-back port
	// ----------------------------------------------------------------
	// read strobe always reads back zero; busy shows as program enable
	always_comb begin
		rdata_nxt = io_rdata_r;
		if (io_rd) begin
			unique case (io_sel)
				nv_ctrl_pkg::SEL_CTRL: begin
					rdata_nxt = nv_ctrl_pkg::CTRL_RESET;
					rdata_nxt[nv_ctrl_pkg::CTRL_MODE_HI_BIT] = mode_r[1];
					rdata_nxt[nv_ctrl_pkg::CTRL_MODE_LO_BIT] = mode_r[0];
					rdata_nxt[nv_ctrl_pkg::CTRL_RIE_BIT] = rie_r;
					rdata_nxt[nv_ctrl_pkg::CTRL_MASTER_BIT] = mpe_r;
					rdata_nxt[nv_ctrl_pkg::CTRL_PROG_BIT] = busy; // [R9]
				end
				nv_ctrl_pkg::SEL_DATA: begin
					rdata_nxt = data_r;
				end
				nv_ctrl_pkg::SEL_ADDR_LO: begin
					rdata_nxt = addr_r[7:0];
				end
				nv_ctrl_pkg::SEL_ADDR_HI: begin
					rdata_nxt = 8'h00;
					rdata_nxt[HI_W-1:0] = addr_r[ADDR_W-1:8];
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			io_rdata_r <= 8'h00;
			rd_pending_r <= 1'b0;
		end else begin
			io_rdata_r <= rdata_nxt;
			rd_pending_r <= rd_req; // [R11]
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign io_rdata = io_rdata_r;
	assign cpu_halt = cpu_halt_r;
	assign ready_irq = irq_r;

endmodule // nv_program_control

`default_nettype wire
